// ===== mbp_host.sv
// Host-side controller driving a multiplexed address/data nonvolatile memory.
// Assumes one 100 MHz clock; pins connect directly to the memory device.
// Functional notes
// - Chip select low for every access
// - Fetch-only use keeps read/write high
// - Fetch strobe held low in moto style
// - Data captured on write strobe rise; on E fall in moto style
// - Next page byte within 100 us
// - Page bytes share bits six upward
`timescale 1ns/1ps
`default_nettype none
module mbp_host #(
    parameter int PAGE_WINDOW = mbp_pkg::PAGE_WINDOW_CYC
) (
    // Clock, reset, enable
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    // Configuration
    input wire logic I_STYLE_MOTO,
    input wire logic I_ABORT_PAGE,
    // User request
    input wire logic I_REQ_VALID,
    input wire logic I_REQ_WRITE,
    input wire logic I_REQ_FETCH,
    input wire logic [12:0] I_REQ_ADDR,
    input wire logic [7:0] I_REQ_WDATA,
    output logic O_REQ_READY,
    output logic O_RSP_VALID,
    output logic [7:0] O_RSP_RDATA,
    output logic O_PAGE_OPEN,
    output logic O_PAGE_REFUSED,
    // Memory pins
    output logic O_ALE,
    output logic O_CE_N,
    output logic O_RD_N,
    output logic O_WR_N,
    output logic O_PROGRAM_FETCH_STROBE_N,
    output logic O_WRITE_INHIBIT,
    output logic [4:0] O_HIGH_ADDR,
    output logic [7:0] O_MUX_ADDR_DATA,
    output logic O_MUX_ADDR_DATA_OE,
    input wire logic [7:0] I_MUX_ADDR_DATA
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_LATCH = 3'b010,
        ST_HOLD = 3'b011,
        ST_STROBE = 3'b100,
        ST_RELEASE = 3'b101
    } mbp_state_t;

    mbp_state_t state_q;
    logic [mbp_pkg::CNT_W-1:0] cnt_q;
    logic [mbp_pkg::CNT_W-1:0] win_q;
    logic write_q;
    logic fetch_q;
    logic [12:0] addr_q;
    logic [7:0] wdata_q;
    logic page_open_q;
    logic [12:mbp_pkg::PAGE_LSB] page_base_q;
    logic [7:0] rd_sync;
    logic same_page;
    logic moto;

    assign moto = I_STYLE_MOTO;
    assign same_page = I_REQ_ADDR[12:mbp_pkg::PAGE_LSB] == page_base_q;

    mbp_sync #(
        .W(8)
    ) u_sync (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_d(I_MUX_ADDR_DATA),
        .o_q(rd_sync)
    );

    // ------------------------------------------------------------
    // Request acceptance
    // ------------------------------------------------------------
    // A write to another page while one is open is refused
    assign O_PAGE_REFUSED = I_REQ_VALID && I_REQ_WRITE && page_open_q && !same_page;
    assign O_REQ_READY = (state_q == ST_IDLE) && !O_PAGE_REFUSED;
    assign O_PAGE_OPEN = page_open_q;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            write_q <= 1'b0;
            fetch_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
        end else if (I_CE) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (I_REQ_VALID && O_REQ_READY) begin
                        write_q <= I_REQ_WRITE;
                        fetch_q <= I_REQ_FETCH && !I_REQ_WRITE && !moto;
                        addr_q <= I_REQ_ADDR;
                        wdata_q <= I_REQ_WDATA;
                        cnt_q <= mbp_pkg::CNT_W'(mbp_pkg::SETUP_CYC);
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == 1) begin
                        cnt_q <= mbp_pkg::CNT_W'(mbp_pkg::ALE_CYC - mbp_pkg::SETUP_CYC);
                        state_q <= ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q <= 1) begin
                        cnt_q <= mbp_pkg::CNT_W'(mbp_pkg::HOLD_CYC);
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == 1) begin
                        cnt_q <= write_q ? mbp_pkg::CNT_W'(mbp_pkg::WR_CYC) : mbp_pkg::CNT_W'(mbp_pkg::ACC_CYC);
                        state_q <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == 1) begin
                        cnt_q <= mbp_pkg::CNT_W'(mbp_pkg::DHOLD_CYC);
                        state_q <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == 1) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic latching;
    logic strobing;
    logic active;
    assign latching = (state_q == ST_SETUP) || (state_q == ST_LATCH);
    assign strobing = state_q == ST_STROBE;
    assign active = state_q != ST_IDLE;

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_ALE <= 1'b1;
            O_CE_N <= 1'b1;
            O_RD_N <= 1'b1;
            O_WR_N <= 1'b1;
            O_PROGRAM_FETCH_STROBE_N <= 1'b1;
            O_HIGH_ADDR <= '0;
            O_MUX_ADDR_DATA <= '0;
            O_MUX_ADDR_DATA_OE <= 1'b0;
        end else if (I_CE) begin
            // Idle: select and latch both high put the device in standby
            O_ALE <= !active || latching;
            // Select held low over the whole access
            O_CE_N <= !active;
            // Address on the pins while latch is high and held after it falls
            O_HIGH_ADDR <= addr_q[12:8];
            O_MUX_ADDR_DATA <= (latching || state_q == ST_HOLD) ? addr_q[7:0] : wdata_q;
            O_MUX_ADDR_DATA_OE <= latching || state_q == ST_HOLD || (write_q && (strobing || state_q == ST_RELEASE));
            if (moto) begin
                // E on the read pin, R/W on the write pin; fetch strobe held low
                O_PROGRAM_FETCH_STROBE_N <= 1'b0;
                O_RD_N <= strobing;
                O_WR_N <= !(active && write_q);
            end else begin
                // Reads via fetch or read strobe; unused ones stay high
                O_PROGRAM_FETCH_STROBE_N <= !(strobing && fetch_q);
                O_RD_N <= !(strobing && !write_q && !fetch_q);
                O_WR_N <= !(strobing && write_q);
            end
        end
    end

    // ------------------------------------------------------------
    // Read data capture
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RSP_VALID <= 1'b0;
            O_RSP_RDATA <= '0;
        end else if (I_CE) begin
            O_RSP_VALID <= 1'b0;
            if (strobing && !write_q && cnt_q == 1) begin
                O_RSP_VALID <= 1'b1;
                O_RSP_RDATA <= rd_sync;
            end
        end
    end

    // ------------------------------------------------------------
    // Page window and write inhibit
    // ------------------------------------------------------------
    logic wr_done;
    assign wr_done = write_q && state_q == ST_RELEASE && cnt_q == 1;

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            page_open_q <= 1'b0;
            page_base_q <= '0;
            win_q <= '0;
        end else if (I_CE) begin
            if (wr_done) begin
                // Each byte restarts the page window
                page_open_q <= 1'b1;
                page_base_q <= addr_q[12:mbp_pkg::PAGE_LSB];
                win_q <= mbp_pkg::CNT_W'(PAGE_WINDOW);
            end else if (page_open_q) begin
                win_q <= win_q - 1'b1;
                if (win_q == 1 || O_WRITE_INHIBIT) begin
                    page_open_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_WRITE_INHIBIT <= 1'b0;
        end else if (I_CE) begin
            // Raised the cycle after I_ABORT_PAGE is seen while a page is open or its byte completes, to abort the page
            O_WRITE_INHIBIT <= I_ABORT_PAGE && (page_open_q || wr_done);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sta_select_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (!O_RD_N || !O_WR_N) && !$past(moto) |-> !O_CE_N)
        else $error("strobe without chip select");
    standby_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_CE && state_q == ST_IDLE |=> O_CE_N && O_ALE)
        else $error("idle not standby");
    ale_addr_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_CE && $past(I_CE) && O_ALE && !O_CE_N |-> O_MUX_ADDR_DATA_OE && O_MUX_ADDR_DATA == addr_q[7:0])
        else $error("address missing while latch high");
    fetch_only_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        !O_PROGRAM_FETCH_STROBE_N && !$past(moto) |-> O_RD_N && O_WR_N)
        else $error("fetch overlaps read or write");
    moto_fetch_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_CE && moto && $past(moto) && $past(I_CE) |-> !O_PROGRAM_FETCH_STROBE_N)
        else $error("fetch strobe not low in moto style");
    wr_data_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        !$past(moto) && $rose(O_WR_N) |-> O_MUX_ADDR_DATA_OE && O_MUX_ADDR_DATA == wdata_q)
        else $error("no data at write strobe rise");
    page_same_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_CE && state_q == ST_IDLE && page_open_q && I_REQ_VALID && I_REQ_WRITE && O_REQ_READY
        |=> addr_q[12:mbp_pkg::PAGE_LSB] == page_base_q)
        else $error("page crossed");
    ale_low_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_CE && $fell(O_ALE) |-> !O_CE_N ##1 (!I_CE || !O_ALE))
        else $error("latch fell outside access");
    addr_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        $fell(O_ALE) |-> O_MUX_ADDR_DATA_OE && O_MUX_ADDR_DATA == addr_q[7:0])
        else $error("address not held after latch fell");
    read_cov: cover property (@(posedge I_CLOCK) O_RSP_VALID && !moto);
    write_cov: cover property (@(posedge I_CLOCK) wr_done);
    moto_cov: cover property (@(posedge I_CLOCK) O_RSP_VALID && moto);
    abort_cov: cover property (@(posedge I_CLOCK) O_WRITE_INHIBIT);
endmodule
`default_nettype wire

// ===== mbp_mem_model.sv
// Behavioural model of the multiplexed-bus memory device on the far side of mbp_host.
// Assumes the bench wires every host pin to it and feeds its o_bus back to the host.
`timescale 1ns/1ps
`default_nettype none
module mbp_mem_model #(
    parameter int PAGE_NS = 600,
    parameter int ACC_NS = 100,
    parameter int PROG_NS = 2000,
    // Sections locked for the whole run, as after power-up
    parameter logic [7:0] LOCKED = 8'h40
) (
    // Strapping and pins
    input wire logic i_moto,
    input wire logic i_ale,
    input wire logic i_ce_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_fetch_n,
    input wire logic i_inhibit,
    input wire logic [4:0] i_high_addr,
    input wire logic [7:0] i_host_ad,
    input wire logic i_host_oe,
    output logic [7:0] o_bus
);
    logic [7:0] mem [0:8191];
    logic [12:0] addr_q = 13'h0000;
    logic [12:0] pa [$];
    logic [7:0] pd [$];
    realtime last_wr = 0;
    realtime prog_end = 0;
    logic prog_plane = 1'b0;
    logic tog = 1'b0;
    // ------------------------------------------------------------
    // Address latch and read drive
    // ------------------------------------------------------------
    wire logic [12:0] addr = i_ale ? {i_high_addr, i_host_ad} : addr_q;
    wire logic rd_act = !i_ce_n && (i_moto ? (i_wr_n && i_rd_n) : (!i_rd_n || !i_fetch_n));
    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'hff;
        end
        o_bus = 8'h00;
    end
    always @(negedge i_ale) begin
        addr_q <= {i_high_addr, i_host_ad};
    end
    // Released bus shows a changing pattern, never the last value
    always @(i_host_oe, i_host_ad, rd_act, addr) begin
        if (i_host_oe) begin
            o_bus <= i_host_ad;
        end else if (rd_act) begin
            if ($realtime < prog_end && addr[12] == prog_plane) begin
                o_bus <= #(ACC_NS) {mem[addr][7], tog, mem[addr][5:0]};
            end else begin
                o_bus <= #(ACC_NS) mem[addr];
            end
        end else begin
            o_bus <= ~o_bus;
        end
    end
    // Busy plane flips its poll bit at the end of each read
    always @(negedge rd_act) begin
        if ($realtime < prog_end && addr[12] == prog_plane) begin
            tog = ~tog;
        end
    end
    // ------------------------------------------------------------
    // Write capture, abort and page commit
    // ------------------------------------------------------------
    task automatic capture();
        if (!i_inhibit && !i_ce_n && !LOCKED[addr_q[12:10]]) begin
            pa.push_back(addr_q);
            pd.push_back(i_host_ad);
            last_wr = $realtime;
        end
    endtask
    always @(posedge i_wr_n) begin
        if (!i_moto) begin
            capture();
        end
    end
    always @(negedge i_rd_n) begin
        if (i_moto && !i_wr_n) begin
            capture();
        end
    end
    always @(posedge i_inhibit) begin
        pa.delete();
        pd.delete();
    end
    always #10 begin
        if (pa.size() > 0 && $realtime - last_wr >= PAGE_NS) begin
            prog_end = $realtime + PROG_NS;
            prog_plane = pa[0][12];
            while (pa.size() > 0) begin
                mem[pa.pop_front()] = pd.pop_front();
            end
        end
    end
endmodule
`default_nettype wire

// ===== mbp_pkg.sv
// Shared constants for the host-side controller of a multiplexed-bus nonvolatile memory.
// Assumes a 100 MHz system clock; all timing below is counted in those cycles.
package mbp_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int ALE_WIDTH_NS = 80;
    localparam int ADDR_SETUP_NS = 20;
    localparam int ADDR_HOLD_NS = 30;
    localparam int ACCESS_NS = 120;
    localparam int WR_WIDTH_NS = 50;
    localparam int DATA_HOLD_NS = 20;
    localparam int PAGE_WINDOW_US = 100;
    localparam int ALE_CYC = (ALE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Access plus pin skew, three synchroniser stages, the agreement stage and capture
    localparam int ACC_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 6;
    localparam int WR_CYC = (WR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DHOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest gap between page bytes, rounded down
    localparam int PAGE_WINDOW_CYC = PAGE_WINDOW_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W = 14;
    // ------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int PAGE_LSB = 6;
    localparam int PLANE_BIT = 12;
    localparam int TOGGLE_BIT = 6;
    // ------------------------------------------------------------
    // Bus styles
    // ------------------------------------------------------------
    typedef enum logic {
        MBP_STYLE_HARVARD = 1'b0,
        MBP_STYLE_MOTO = 1'b1
    } mbp_style_t;
endpackage

// ===== mbp_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module mbp_sync #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            o_q <= '0;
        end else if (i_ce) begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Accept a change only once two later stages agree
            for (int k = 0; k < W; k++) begin
                if (s2_q[k] == s3_q[k]) begin
                    o_q[k] <= s3_q[k];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for mbp_host against the memory model.
// Assumes a 100 MHz clock and a shortened page window of 50 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst_n = 0, moto = 0, abort = 0, valid = 0, wr = 0, fetch = 0, ce = 1, moto_d = 0;
    logic [12:0] addr = 13'h0000;
    logic [7:0] wdata = 8'h00;
    logic ready, rsp_valid, page_open, refused, ale, ce_n, rd_n, wr_n, fetch_n, inhibit, ad_oe;
    logic [4:0] high;
    logic [7:0] rdata, ad, bus;
    int errors = 0, checks = 0;
    always #5 clk = ~clk;
    mbp_host #(.PAGE_WINDOW(50)) dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_STYLE_MOTO(moto),
        .I_ABORT_PAGE(abort), .I_REQ_VALID(valid), .I_REQ_WRITE(wr), .I_REQ_FETCH(fetch), .I_REQ_ADDR(addr),
        .I_REQ_WDATA(wdata), .O_REQ_READY(ready), .O_RSP_VALID(rsp_valid), .O_RSP_RDATA(rdata),
        .O_PAGE_OPEN(page_open), .O_PAGE_REFUSED(refused), .O_ALE(ale), .O_CE_N(ce_n), .O_RD_N(rd_n),
        .O_WR_N(wr_n), .O_PROGRAM_FETCH_STROBE_N(fetch_n), .O_WRITE_INHIBIT(inhibit), .O_HIGH_ADDR(high),
        .O_MUX_ADDR_DATA(ad), .O_MUX_ADDR_DATA_OE(ad_oe), .I_MUX_ADDR_DATA(bus));
    mbp_mem_model #(.PAGE_NS(600), .ACC_NS(120), .PROG_NS(2000), .LOCKED(8'h40)) model (.i_moto(moto),
        .i_ale(ale), .i_ce_n(ce_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_fetch_n(fetch_n), .i_inhibit(inhibit), .i_high_addr(high),
        .i_host_ad(ad), .i_host_oe(ad_oe), .o_bus(bus));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic fail(input string what);
        errors++;
        $display("Error at %0t: %s timed out", $time, what);
        give_verdict();
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (ready !== 1'b1 && n < 200);
        if (ready !== 1'b1) fail("ready");
    endtask
    task automatic issue(input logic w, input logic f, input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        valid <= 1'b1;
        wr <= w;
        fetch <= f;
        addr <= a;
        wdata <= d;
        wait_ready();
        @(posedge clk);
        valid <= 1'b0;
    endtask
    task automatic wait_close();
        int n;
        n = 0;
        wait_ready();
        while (page_open !== 1'b0 && n < 300) begin @(negedge clk); n++; end
        if (page_open !== 1'b0) fail("page close");
        repeat (240) @(negedge clk);
    endtask
    task automatic rd_chk(input logic f, input logic [12:0] a, input logic [7:0] exp, input string what);
        int n;
        n = 0;
        issue(1'b0, f, a, 8'h00);
        while (rsp_valid !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        if (rsp_valid !== 1'b1) fail(what);
        chk(rdata, exp, what);
    endtask
    // Strobes only while the device is selected; pins follow the style one cycle late
    always @(posedge clk) moto_d <= moto;
    always @(negedge clk) begin
        if (rst_n && !moto && !moto_d && (rd_n === 1'b0 || wr_n === 1'b0 || fetch_n === 1'b0)) begin
            chk({7'h00, ce_n}, 8'h00, "strobe without select");
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_idle();
        chk({ale, ce_n, rd_n, wr_n, fetch_n, inhibit, ad_oe, 1'b0}, 8'hf8, "idle pins");
    endtask
    task automatic t_strobe_set();
        issue(1'b1, 1'b0, 13'h0123, 8'h5a);
        wait_close();
        issue(1'b1, 1'b0, 13'h1fc4, 8'ha5);
        wait_close();
        rd_chk(1'b0, 13'h0123, 8'h5a, "read strobe");
        rd_chk(1'b1, 13'h0123, 8'h5a, "fetch strobe");
        rd_chk(1'b1, 13'h1fc4, 8'ha5, "high plane");
    endtask
    task automatic t_freeze();
        int n;
        n = 0;
        issue(1'b0, 1'b0, 13'h0123, 8'h00);
        @(posedge clk);
        ce <= 1'b0;
        repeat (40) @(negedge clk);
        chk({5'h00, ale, ce_n, ad_oe}, 8'h05, "frozen in latch phase");
        @(posedge clk);
        ce <= 1'b1;
        while (rsp_valid !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        if (rsp_valid !== 1'b1) fail("read after freeze");
        chk(rdata, 8'h5a, "read after freeze");
    endtask
    task automatic t_moto();
        wait_ready();
        @(posedge clk);
        moto <= 1'b1;
        issue(1'b1, 1'b0, 13'h0a3c, 8'h3c);
        wait_close();
        rd_chk(1'b0, 13'h0a3c, 8'h3c, "bus style read");
        wait_ready();
        @(posedge clk);
        moto <= 1'b0;
    endtask
    task automatic t_abort();
        int n;
        n = 0;
        issue(1'b1, 1'b0, 13'h0200, 8'h77);
        wait_ready();
        @(posedge clk);
        abort <= 1'b1;
        while (inhibit !== 1'b1 && n < 4) begin @(negedge clk); n++; end
        chk({7'h00, inhibit}, 8'h01, "inhibit raised");
        @(posedge clk);
        abort <= 1'b0;
        wait_close();
        rd_chk(1'b0, 13'h0200, 8'hff, "aborted byte");
    endtask
    task automatic t_page();
        issue(1'b1, 1'b0, 13'h0440, 8'h11);
        issue(1'b1, 1'b0, 13'h0441, 8'h12);
        wait_ready();
        @(posedge clk);
        valid <= 1'b1;
        addr <= 13'h0480;
        @(negedge clk);
        chk({6'h00, refused, ready}, 8'h02, "other page refused");
        @(posedge clk);
        valid <= 1'b0;
        wait_close();
        rd_chk(1'b0, 13'h0440, 8'h11, "page byte 0");
        rd_chk(1'b0, 13'h0441, 8'h12, "page byte 1");
        rd_chk(1'b0, 13'h0480, 8'hff, "refused byte");
    endtask
    task automatic t_plane();
        int n;
        n = 0;
        issue(1'b1, 1'b0, 13'h1800, 8'h66);
        wait_close();
        rd_chk(1'b0, 13'h1800, 8'hff, "locked section");
        issue(1'b1, 1'b0, 13'h0300, 8'h00);
        wait_ready();
        while (page_open !== 1'b0 && n < 300) begin @(negedge clk); n++; end
        if (page_open !== 1'b0) fail("page close");
        repeat (15) @(negedge clk);
        rd_chk(1'b0, 13'h1fc4, 8'ha5, "other plane while busy");
        rd_chk(1'b0, 13'h0300, 8'h00, "first poll");
        rd_chk(1'b0, 13'h0300, 8'h40, "second poll");
        repeat (150) @(negedge clk);
        rd_chk(1'b0, 13'h0300, 8'h00, "toggle stopped");
    endtask
    initial begin
        repeat (8) @(negedge clk);
        t_idle();
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        t_idle();
        t_strobe_set();
        t_freeze();
        t_moto();
        t_abort();
        t_page();
        t_plane();
        give_verdict();
    end
endmodule
`default_nettype wire
